// ==== vbus_fault_discharge_seq_defines.vh ====
`ifndef VBUS_FAULT_DISCHARGE_SEQ_DEFINES_VH
`define VBUS_FAULT_DISCHARGE_SEQ_DEFINES_VH

// Clock and unit scaling
`define VFD_CLK_NS 8
`define VFD_NS_PER_MS 1000000
`define VFD_NS_PER_US 1000

// Times in their own units
`define VFD_SHUTDOWN_MS 25
`define VFD_UNPLUG_US 20
`define VFD_DISCHARGE_MS 650
`define VFD_TRANSITION_MS 600
`define VFD_REARM_MS 765
`define VFD_FOVP_WIN_MS (`VFD_DISCHARGE_MS + `VFD_REARM_MS)

// Cycle counts: least times round up, longest times round down
`define VFD_SHUTDOWN_CYC ((`VFD_SHUTDOWN_MS * `VFD_NS_PER_MS + `VFD_CLK_NS - 1) / `VFD_CLK_NS)
`define VFD_UNPLUG_CYC ((`VFD_UNPLUG_US * `VFD_NS_PER_US - 1) / `VFD_CLK_NS)
`define VFD_DISCHARGE_CYC ((`VFD_DISCHARGE_MS * `VFD_NS_PER_MS) / `VFD_CLK_NS)
`define VFD_TRANSITION_CYC ((`VFD_TRANSITION_MS * `VFD_NS_PER_MS) / `VFD_CLK_NS)
`define VFD_REARM_CYC ((`VFD_REARM_MS * `VFD_NS_PER_MS + `VFD_CLK_NS - 1) / `VFD_CLK_NS)
`define VFD_FOVP_WIN_CYC ((`VFD_FOVP_WIN_MS * `VFD_NS_PER_MS) / `VFD_CLK_NS)

// Widths and small constants
`define VFD_TMR_W 28
`define VFD_TMR_ONE 28'h0000001
`define VFD_TMR_ZERO 28'h0000000
`define VFD_SYNC_W 16
`define VFD_STRAP_SETTLE 2'h3
`define VFD_RETRY_MAX 8'hff
`define VFD_SEL5_A 1'h0
`define VFD_SEL5_B 1'h0

// Fault cause codes
`define VFD_CAUSE_NONE 4'h0
`define VFD_CAUSE_HRRX 4'h1
`define VFD_CAUSE_UNPLUG 4'h2
`define VFD_CAUSE_OTEMP 4'h3
`define VFD_CAUSE_LOWV 4'h4
`define VFD_CAUSE_HIGHV 4'h5
`define VFD_CAUSE_UNEXP 4'h6
`define VFD_CAUSE_TRANS 4'h7
`define VFD_CAUSE_SOFTRST 4'h8
`define VFD_CAUSE_REQTO 4'h9
`define VFD_CAUSE_DISFAIL 4'ha
`define VFD_CAUSE_FOVP 4'hb
`define VFD_CAUSE_OCP 4'hc
`define VFD_CAUSE_GATEDIS 4'hd
`define VFD_CAUSE_SUPOVP 4'he

`endif

// ==== vfd_sync2.v ====
`timescale 1ns/100ps
// Two-flop synchroniser for a vector of independent levels
module vfd_sync2 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;

  always @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= {WIDTH{1'h0}};
      syncOut <= {WIDTH{1'h0}};
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// ==== vbus_fault_discharge_seq.v ====
`timescale 1ns/100ps
// Operation
// - Slow fault: keep FET gate on until VBUS below 5V slow overvoltage level.
// - Fast fault: release FET gate at once and start connector-side discharge on the same clock edge.
// - Both fault classes apply weak bleed and supply bleed current during shutdown.
// - Received hard reset is slow fault, 25-35 ms delay; unplug under 20 us.
// - Overtemp, alarms outside transition, odd message in transition, 600 ms transition miss send reset.
// - Soft reset not accepted or request deadline missed: slow fault with reset.
// - VBUS failing to reach 0.725 V after a fault: slow fault with reset.
// - Fast overvoltage, overcurrent after first message, gate-disable fall: fast fault.
// - VBUS below present-fall threshold counts as overcurrent.
// - Hard reset of a slow fault is sent when the shutdown delay starts.
// - After delay, select 5 V on both lines and turn on full discharge.
// - At 5V slow overvoltage level release gate; full discharge to 0.725 V.
// - Discharge not done in 650 ms: send hard reset and restart.
// - Fast shutdown draws supply bleed once the gate output is off.
// - Supply above fast overvoltage too long: overvoltage event, repeat procedure.
// - Failed discharge is a slow fault; repeat until it succeeds.
// - After discharge below 0.725 V wait 0.765 s before sourcing again.
// - Voltage strap change sends nothing; strap sampled before each capabilities message.
// - Any power-halving input change recalculates and resends capabilities.
// - Current-limit strap sampled once after reset and latched.
// - 12/20 V variant: voltage and current straps pick the advertised set.
// - 9/15 V variant: same strap selection with 9 and 15 V.
`include "vbus_fault_discharge_seq_defines.vh"

module vbus_fault_discharge_seq #(
  parameter [`VFD_TMR_W-1:0] SHUTDOWN_CYC = `VFD_SHUTDOWN_CYC,
  parameter [`VFD_TMR_W-1:0] DISCHARGE_CYC = `VFD_DISCHARGE_CYC,
  parameter [`VFD_TMR_W-1:0] TRANSITION_CYC = `VFD_TRANSITION_CYC,
  parameter [`VFD_TMR_W-1:0] REARM_CYC = `VFD_REARM_CYC,
  parameter [`VFD_TMR_W-1:0] FOVP_WIN_CYC = `VFD_FOVP_WIN_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire hardResetRcvd,
  input wire cableUnplug,
  input wire softResetFail,
  input wire requestTimeout,
  input wire unexpectedMsg,
  input wire transitionActive,
  input wire firstMsgSent,
  input wire sourceRequest,
  input wire reqSelectA,
  input wire reqSelectB,
  input wire capsRequest,
  input wire overTemp,
  input wire lowVoltAlarm,
  input wire highVoltAlarm,
  input wire fastOvpFlag,
  input wire overCurrentFlag,
  input wire vbusBelowPresent,
  input wire gateDisableInput,
  input wire vbusBelowSovp,
  input wire vbusBelowSafe,
  input wire supplyAboveFovp,
  input wire powerHalvingInput,
  input wire midVoltageStrap12,
  input wire midVoltageStrap9,
  input wire currentLimitStrapDirect,
  input wire currentLimitStrapHigh,
  input wire variantNineFifteen,
  output reg fetGateDrive,
  output reg dischargeBleed,
  output reg dischargeFull,
  output reg supplyBleed,
  output reg supplySelectA,
  output reg supplySelectB,
  output reg hardResetTx,
  output reg sourceAllowed,
  output reg capsSend,
  output reg advMid,
  output reg advHigh,
  output reg advHalfPower,
  output reg currentLimit3A,
  output reg [3:0] faultCause,
  output reg [7:0] retryCount
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_SHUT = 6'h02;
  localparam [5:0] ST_SLOW = 6'h04;
  localparam [5:0] ST_FIN = 6'h08;
  localparam [5:0] ST_FAST = 6'h10;
  localparam [5:0] ST_WAIT = 6'h20;
  localparam [`VFD_TMR_W-1:0] UNPLUG_CYC = `VFD_UNPLUG_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  wire [`VFD_SYNC_W-1:0] syncVec;
  wire sOverTemp;
  wire sLowAlarm;
  wire sHighAlarm;
  wire sFastOvp;
  wire sOverCurrent;
  wire sBelowPresent;
  wire sGateDisable;
  wire sBelowSovp;
  wire sBelowSafe;
  wire sSupplyHigh;
  wire sHalving;
  wire sStrap12;
  wire sStrap9;
  wire sLimitDirect;
  wire sLimitHigh;
  wire sVariant;

  vfd_sync2 #(
    .WIDTH(`VFD_SYNC_W)
  ) inputSync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn({overTemp, lowVoltAlarm, highVoltAlarm, fastOvpFlag, overCurrentFlag,
      vbusBelowPresent, gateDisableInput, vbusBelowSovp, vbusBelowSafe,
      supplyAboveFovp, powerHalvingInput, midVoltageStrap12, midVoltageStrap9,
      currentLimitStrapDirect, currentLimitStrapHigh, variantNineFifteen}),
    .syncOut(syncVec)
  );

  assign {sOverTemp, sLowAlarm, sHighAlarm, sFastOvp, sOverCurrent, sBelowPresent,
    sGateDisable, sBelowSovp, sBelowSafe, sSupplyHigh, sHalving, sStrap12,
    sStrap9, sLimitDirect, sLimitHigh, sVariant} = syncVec;

  ////////////////////////////////////////////////////////////////////////////
  // Fault classification

  reg [5:0] state;
  reg [`VFD_TMR_W-1:0] timer;
  reg [`VFD_TMR_W-1:0] ovpTimer;
  reg [`VFD_TMR_W-1:0] transTimer;
  reg gateDisPrev;
  reg [3:0] slowCause;
  reg slowTx;
  reg [3:0] fastCause;
  wire gateDisFall;
  wire transTimeout;
  wire slowFault;
  wire fastFault;
  wire timerDone;
  wire ovpDone;

  assign gateDisFall = gateDisPrev & ~sGateDisable;
  assign transTimeout = transitionActive & (transTimer == `VFD_TMR_ONE);
  assign timerDone = (timer == `VFD_TMR_ONE);
  assign ovpDone = sSupplyHigh & (ovpTimer == `VFD_TMR_ONE);

  // Reset-sending causes outrank the silent ones so a hard reset is never lost
  always @* begin
    slowCause = `VFD_CAUSE_NONE;
    slowTx = 1'h1;
    if (sOverTemp) begin
      slowCause = `VFD_CAUSE_OTEMP;
    end else if (sLowAlarm & ~transitionActive) begin
      slowCause = `VFD_CAUSE_LOWV;
    end else if (sHighAlarm & ~transitionActive) begin
      slowCause = `VFD_CAUSE_HIGHV;
    end else if (unexpectedMsg & transitionActive) begin
      slowCause = `VFD_CAUSE_UNEXP;
    end else if (transTimeout) begin
      slowCause = `VFD_CAUSE_TRANS;
    end else if (softResetFail) begin
      slowCause = `VFD_CAUSE_SOFTRST;
    end else if (requestTimeout) begin
      slowCause = `VFD_CAUSE_REQTO;
    end else if (hardResetRcvd) begin
      slowCause = `VFD_CAUSE_HRRX;
      slowTx = 1'h0;
    end else if (cableUnplug) begin
      slowCause = `VFD_CAUSE_UNPLUG;
      slowTx = 1'h0;
    end
  end

  always @* begin
    fastCause = `VFD_CAUSE_NONE;
    if (sFastOvp) begin
      fastCause = `VFD_CAUSE_FOVP;
    end else if ((sOverCurrent | sBelowPresent) & firstMsgSent) begin
      fastCause = `VFD_CAUSE_OCP;
    end else if (gateDisFall) begin
      fastCause = `VFD_CAUSE_GATEDIS;
    end
  end

  assign slowFault = (slowCause != `VFD_CAUSE_NONE);
  assign fastFault = (fastCause != `VFD_CAUSE_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown and discharge sequencer

  always @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      timer <= `VFD_TMR_ZERO;
      ovpTimer <= `VFD_TMR_ZERO;
      transTimer <= TRANSITION_CYC;
      gateDisPrev <= 1'h0;
      fetGateDrive <= 1'h0;
      dischargeBleed <= 1'h0;
      dischargeFull <= 1'h0;
      supplyBleed <= 1'h0;
      supplySelectA <= `VFD_SEL5_A;
      supplySelectB <= `VFD_SEL5_B;
      hardResetTx <= 1'h0;
      sourceAllowed <= 1'h1;
      faultCause <= `VFD_CAUSE_NONE;
      retryCount <= 8'h00;
    end else begin
      hardResetTx <= 1'h0;
      gateDisPrev <= sGateDisable;
      if (state == ST_IDLE && transitionActive) begin
        transTimer <= transTimer - `VFD_TMR_ONE;
      end else begin
        transTimer <= TRANSITION_CYC;
      end
      case (state)
        ST_IDLE: begin
          fetGateDrive <= sourceRequest & sourceAllowed;
          supplySelectA <= reqSelectA;
          supplySelectB <= reqSelectB;
          dischargeBleed <= 1'h0;
          dischargeFull <= 1'h0;
          supplyBleed <= 1'h0;
          if (slowFault) begin
            state <= ST_SHUT;
            timer <= (slowCause == `VFD_CAUSE_UNPLUG) ? UNPLUG_CYC : SHUTDOWN_CYC;
            hardResetTx <= slowTx;
            sourceAllowed <= 1'h0;
            dischargeBleed <= 1'h1;
            supplyBleed <= 1'h1;
            faultCause <= slowCause;
          end
        end
        ST_SHUT: begin
          timer <= timer - `VFD_TMR_ONE;
          if (timerDone) begin
            state <= ST_SLOW;
            timer <= DISCHARGE_CYC;
            supplySelectA <= `VFD_SEL5_A;
            supplySelectB <= `VFD_SEL5_B;
            dischargeFull <= 1'h1;
          end
        end
        ST_SLOW: begin
          timer <= timer - `VFD_TMR_ONE;
          if (sBelowSovp) begin
            state <= ST_FIN;
            fetGateDrive <= 1'h0;
          end else if (timerDone) begin
            state <= ST_SHUT;
            timer <= SHUTDOWN_CYC;
            hardResetTx <= 1'h1;
            dischargeFull <= 1'h0;
            faultCause <= `VFD_CAUSE_DISFAIL;
            retryCount <= (retryCount == `VFD_RETRY_MAX) ? retryCount : retryCount + 8'h01;
          end
        end
        ST_FIN: begin
          timer <= timer - `VFD_TMR_ONE;
          if (sBelowSafe) begin
            state <= ST_WAIT;
            timer <= REARM_CYC;
            dischargeFull <= 1'h0;
            dischargeBleed <= 1'h0;
            supplyBleed <= 1'h0;
          end else if (timerDone) begin
            state <= ST_SHUT;
            timer <= SHUTDOWN_CYC;
            hardResetTx <= 1'h1;
            dischargeFull <= 1'h0;
            faultCause <= `VFD_CAUSE_DISFAIL;
            retryCount <= (retryCount == `VFD_RETRY_MAX) ? retryCount : retryCount + 8'h01;
          end
        end
        ST_FAST: begin
          timer <= timer - `VFD_TMR_ONE;
          // Bleed waits for the registered gate to be seen off, so the
          // supply is never loaded while it still feeds the connector
          supplyBleed <= ~fetGateDrive;
          if (sSupplyHigh) begin
            ovpTimer <= ovpTimer - `VFD_TMR_ONE;
          end else begin
            ovpTimer <= FOVP_WIN_CYC;
          end
          if (ovpDone) begin
            timer <= DISCHARGE_CYC;
            ovpTimer <= FOVP_WIN_CYC;
            hardResetTx <= 1'h1;
            faultCause <= `VFD_CAUSE_SUPOVP;
            retryCount <= (retryCount == `VFD_RETRY_MAX) ? retryCount : retryCount + 8'h01;
          end else if (sBelowSafe & ~sSupplyHigh) begin
            state <= ST_WAIT;
            timer <= REARM_CYC;
            dischargeFull <= 1'h0;
            dischargeBleed <= 1'h0;
            supplyBleed <= 1'h0;
          end else if (timerDone & ~sBelowSafe) begin
            state <= ST_SHUT;
            timer <= SHUTDOWN_CYC;
            hardResetTx <= 1'h1;
            dischargeFull <= 1'h0;
            faultCause <= `VFD_CAUSE_DISFAIL;
            retryCount <= (retryCount == `VFD_RETRY_MAX) ? retryCount : retryCount + 8'h01;
          end
        end
        ST_WAIT: begin
          timer <= timer - `VFD_TMR_ONE;
          if (timerDone) begin
            state <= ST_IDLE;
            sourceAllowed <= 1'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // Fast faults preempt any slow step; a fast shutdown already running
      // handles its own repeats
      if (fastFault && state != ST_FAST) begin
        state <= ST_FAST;
        fetGateDrive <= 1'h0;
        dischargeFull <= 1'h1;
        dischargeBleed <= 1'h1;
        supplyBleed <= 1'h0;
        supplySelectA <= `VFD_SEL5_A;
        supplySelectB <= `VFD_SEL5_B;
        hardResetTx <= 1'h1;
        sourceAllowed <= 1'h0;
        timer <= DISCHARGE_CYC;
        ovpTimer <= FOVP_WIN_CYC;
        faultCause <= fastCause;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap latch and capabilities

  reg [1:0] strapCnt;
  reg strapLatched;
  reg limitDirect;
  reg halvingPrev;
  wire voltStrap;

  // Only one variant's strap is wired in a given build; the tie picks it
  assign voltStrap = sVariant ? sStrap9 : sStrap12;

  always @(posedge clk) begin
    if (!rst_n) begin
      strapCnt <= 2'h0;
      strapLatched <= 1'h0;
      limitDirect <= 1'h0;
      currentLimit3A <= 1'h0;
      halvingPrev <= 1'h0;
      capsSend <= 1'h0;
      advMid <= 1'h0;
      advHigh <= 1'h0;
      advHalfPower <= 1'h0;
    end else begin
      capsSend <= 1'h0;
      halvingPrev <= sHalving;
      if (!strapLatched) begin
        // Wait for the synchroniser to fill before trusting the strap
        if (strapCnt == `VFD_STRAP_SETTLE) begin
          strapLatched <= 1'h1;
          limitDirect <= sLimitDirect;
          currentLimit3A <= sLimitHigh;
        end else begin
          strapCnt <= strapCnt + 2'h1;
        end
      end else if (capsRequest || (sHalving != halvingPrev)) begin
        advMid <= ~voltStrap;
        advHigh <= limitDirect;
        advHalfPower <= ~sHalving;
        capsSend <= 1'h1;
      end
    end
  end

endmodule

// ==== vfd_checker_sva.sv ====
`timescale 1ns/100ps
module vfd_checker #(
  parameter int SHUTDOWN_CYC = 20,
  parameter int REARM_CYC = 30
) (
  input wire clk,
  input wire rst_n,
  input wire softResetFail,
  input wire hardResetRcvd,
  input wire fastOvpFlag,
  input wire capsRequest,
  input wire vbusBelowSovp,
  input wire fetGateDrive,
  input wire dischargeBleed,
  input wire dischargeFull,
  input wire supplyBleed,
  input wire supplySelectA,
  input wire supplySelectB,
  input wire hardResetTx,
  input wire sourceAllowed,
  input wire capsSend,
  input wire [3:0] faultCause,
  input wire [7:0] retryCount
);
  localparam int SD_LO = SHUTDOWN_CYC - 1;
  localparam int SD_HI = SHUTDOWN_CYC + 2;
  reg [3:0] upCnt;
  reg [15:0] quietCnt;
  always @(posedge clk) begin
    if (!rst_n) begin
      upCnt <= 4'h0;
    end else if (upCnt != 4'hf) begin
      upCnt <= upCnt + 4'h1;
    end
  end
  // Rearm wait is timed from the end of full discharge
  always @(posedge clk) begin
    if (!rst_n || dischargeFull) begin
      quietCnt <= 16'h0;
    end else if (quietCnt != 16'hffff) begin
      quietCnt <= quietCnt + 16'h1;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_slow_hreset: assert property (
    sourceAllowed && softResetFail |=> hardResetTx && faultCause == 4'h8
      && dischargeBleed && supplyBleed) else $error("slow fault sent no hard reset");
  chk_hrrx_quiet: assert property (
    sourceAllowed && hardResetRcvd |=> !hardResetTx && faultCause == 4'h1)
    else $error("received hard reset answered wrongly");
  chk_delay_hold: assert property (
    sourceAllowed && softResetFail |=> !dischargeFull [*8]) else $error("discharge early");
  chk_delay_full: assert property (
    sourceAllowed && softResetFail |-> ##[SD_LO:SD_HI]
      (dischargeFull && !supplySelectA && !supplySelectB)) else $error("no discharge at 5 V");
  chk_gate_sovp: assert property (
    $fell(fetGateDrive) && $past(dischargeFull) && !hardResetTx |-> $past(vbusBelowSovp, 3))
    else $error("gate released above level");
  chk_fast_gate: assert property (
    sourceAllowed && $rose(fastOvpFlag) |-> ##[1:4] (hardResetTx && !fetGateDrive
      && dischargeFull)) else $error("fast fault not handled");
  chk_fast_bleed: assert property (
    $fell(fetGateDrive) && hardResetTx && !$past(dischargeFull) |=> supplyBleed)
    else $error("no supply bleed after gate off");
  chk_rearm_wait: assert property (
    $rose(sourceAllowed) |-> quietCnt >= REARM_CYC - 2 && quietCnt <= REARM_CYC + 2)
    else $error("rearm wait wrong");
  chk_retry_step: assert property (
    retryCount != $past(retryCount) |-> retryCount == $past(retryCount) + 8'h1
      && (hardResetTx || $past(hardResetTx))) else $error("retry count step wrong");
  chk_caps_reply: assert property (
    capsRequest && upCnt > 4'h6 |=> capsSend) else $error("caps request not answered");
  cover property (hardResetTx && faultCause == 4'hb);
  cover property ($rose(retryCount[0]));
  cover property ($rose(sourceAllowed));
  cover property (hardResetTx && faultCause == 4'he);
endmodule

bind vbus_fault_discharge_seq vfd_checker #(.SHUTDOWN_CYC(SHUTDOWN_CYC),
  .REARM_CYC(REARM_CYC)) vfd_checker_i (.clk(clk), .rst_n(rst_n),
  .softResetFail(softResetFail), .hardResetRcvd(hardResetRcvd), .fastOvpFlag(fastOvpFlag),
  .capsRequest(capsRequest), .vbusBelowSovp(vbusBelowSovp), .fetGateDrive(fetGateDrive),
  .dischargeBleed(dischargeBleed), .dischargeFull(dischargeFull),
  .supplyBleed(supplyBleed), .supplySelectA(supplySelectA), .supplySelectB(supplySelectB),
  .hardResetTx(hardResetTx), .sourceAllowed(sourceAllowed), .capsSend(capsSend),
  .faultCause(faultCause), .retryCount(retryCount));

// ==== vbus_plant.sv ====
`timescale 1ns/100ps
module vbus_plant (
  input wire clk,
  input wire fetGateDrive,
  input wire dischargeFull,
  input wire supplyBleed,
  input wire [1:0] stall,
  output wire vbusBelowSovp,
  output wire vbusBelowSafe,
  output wire supplyAboveFovp
);
  reg [4:0] vbus = 5'h0;
  reg [4:0] supply = 5'h1f;
  // Stall stands for a discharge path too weak to finish in time
  always @(posedge clk) begin
    if (dischargeFull && !stall[0] && vbus != 5'h0) begin
      vbus <= vbus - 5'h1;
    end else if (fetGateDrive && !dischargeFull && vbus != 5'h1f) begin
      vbus <= vbus + 5'h1;
    end
    if (supplyBleed && !stall[1] && supply != 5'h0) begin
      supply <= supply - 5'h1;
    end else if (!supplyBleed && supply != 5'h1f) begin
      supply <= supply + 5'h1;
    end
  end
  assign vbusBelowSovp = vbus < 5'h0a;
  assign vbusBelowSafe = vbus == 5'h0;
  assign supplyAboveFovp = supply > 5'h18;
endmodule

// ==== tb_vbus_fault_discharge_seq.sv ====
`timescale 1ns/100ps
module tb_vbus_fault_discharge_seq;
  // Expected cause per fault index, index 0 in the low nibble
  localparam [47:0] CAUSES = 48'hdccb_6543_9821;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [11:0] flt = 12'h0;
  reg transitionActive = 1'b0;
  reg firstMsgSent = 1'b0;
  reg reqSelectA = 1'b0;
  reg reqSelectB = 1'b0;
  reg capsRequest = 1'b0;
  reg powerHalvingInput = 1'b1;
  reg midVoltageStrap12 = 1'b0;
  reg midVoltageStrap9 = 1'b0;
  reg currentLimitStrapDirect = 1'b0;
  reg currentLimitStrapHigh = 1'b0;
  reg variantNineFifteen = 1'b0;
  reg [1:0] stall = 2'b00;
  reg sourceRequest = 1'b1;
  reg latDirect;
  reg latHigh;
  reg [31:0] r;
  reg [4:0] noteHr[$];
  reg [2:0] noteCaps[$];
  integer seed = 68691;
  integer mismatches = 0;
  integer cmpCount = 0;
  integer i;
  integer n;
  wire vbusBelowSovp, vbusBelowSafe, supplyAboveFovp, fetGateDrive, dischargeFull;
  wire supplyBleed, hardResetTx, sourceAllowed, capsSend, advMid, advHigh, advHalfPower;
  wire currentLimit3A;
  wire dischargeBleed, supplySelectA, supplySelectB;
  wire [3:0] faultCause;
  wire [7:0] retryCount;

  vbus_fault_discharge_seq #(.SHUTDOWN_CYC(28'h14), .DISCHARGE_CYC(28'h3c),
    .TRANSITION_CYC(28'h28), .REARM_CYC(28'h1e), .FOVP_WIN_CYC(28'h64))
  vbus_fault_discharge_seq_i (.clk(clk), .rst_n(rst_n), .hardResetRcvd(flt[0]),
    .cableUnplug(flt[1]), .softResetFail(flt[2]), .requestTimeout(flt[3]),
    .overTemp(flt[4]), .lowVoltAlarm(flt[5]), .highVoltAlarm(flt[6]),
    .unexpectedMsg(flt[7]), .fastOvpFlag(flt[8]), .overCurrentFlag(flt[9]),
    .vbusBelowPresent(flt[10]), .gateDisableInput(~flt[11]),
    .transitionActive(transitionActive), .firstMsgSent(firstMsgSent),
    .sourceRequest(sourceRequest),
    .reqSelectA(reqSelectA), .reqSelectB(reqSelectB), .capsRequest(capsRequest),
    .vbusBelowSovp(vbusBelowSovp), .vbusBelowSafe(vbusBelowSafe),
    .supplyAboveFovp(supplyAboveFovp), .powerHalvingInput(powerHalvingInput),
    .midVoltageStrap12(midVoltageStrap12), .midVoltageStrap9(midVoltageStrap9),
    .currentLimitStrapDirect(currentLimitStrapDirect),
    .currentLimitStrapHigh(currentLimitStrapHigh), .variantNineFifteen(variantNineFifteen),
    .fetGateDrive(fetGateDrive), .dischargeBleed(dischargeBleed), .dischargeFull(dischargeFull),
    .supplyBleed(supplyBleed), .supplySelectA(supplySelectA), .supplySelectB(supplySelectB),
    .hardResetTx(hardResetTx), .sourceAllowed(sourceAllowed), .capsSend(capsSend),
    .advMid(advMid), .advHigh(advHigh), .advHalfPower(advHalfPower),
    .currentLimit3A(currentLimit3A), .faultCause(faultCause), .retryCount(retryCount));

  vbus_plant vbus_plant_i (.clk(clk), .fetGateDrive(fetGateDrive),
    .dischargeFull(dischargeFull), .supplyBleed(supplyBleed), .stall(stall),
    .vbusBelowSovp(vbusBelowSovp), .vbusBelowSafe(vbusBelowSafe),
    .supplyAboveFovp(supplyAboveFovp));

  always #4 clk = ~clk;
  ////////////////////////////////////////
  task check(input [15:0] seen, input [15:0] exp);
    begin
      cmpCount = cmpCount + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task conclude;
    begin
      $display("compares %0d mismatches %0d", cmpCount, mismatches);
      if (mismatches == 0 && cmpCount > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task waitLevel(input integer lim, input reg lvl);
    begin
      n = 0;
      while (sourceAllowed !== lvl && n < lim) begin
        @(posedge clk);
        n = n + 1;
      end
      check(sourceAllowed, lvl);
    end
  endtask

  task doReset(input reg nine, input reg direct, input reg high);
    begin
      rst_n <= 1'b0;
      variantNineFifteen <= nine;
      currentLimitStrapDirect <= direct;
      currentLimitStrapHigh <= high;
      latDirect = direct;
      latHigh = high;
      repeat (6) @(posedge clk);
      check({sourceAllowed, hardResetTx, capsSend, faultCause, retryCount}, 16'h4000);
      rst_n <= 1'b1;
      repeat (40) @(posedge clk);
      check(currentLimit3A, latHigh);
    end
  endtask

  // A strap change alone must leave the caps queue untouched
  task capsRound;
    begin
      r = $random(seed);
      midVoltageStrap12 <= r[0];
      midVoltageStrap9 <= r[1];
      currentLimitStrapDirect <= r[2];
      repeat (4) @(posedge clk);
      noteCaps.push_back({~(variantNineFifteen ? r[1] : r[0]), latDirect, ~powerHalvingInput});
      capsRequest <= 1'b1;
      @(posedge clk);
      capsRequest <= 1'b0;
      noteCaps.push_back({~(variantNineFifteen ? r[1] : r[0]), latDirect, powerHalvingInput});
      powerHalvingInput <= ~powerHalvingInput;
      repeat (8) @(posedge clk);
    end
  endtask

  task noFault(input integer idx);
    begin
      flt <= 12'h001 << idx;
      repeat (4) @(posedge clk);
      flt <= 12'h000;
      repeat (6) @(posedge clk);
      check(sourceAllowed, 1'b1);
    end
  endtask

  task runFault(input integer idx);
    begin
      if (idx > 1) noteHr.push_back({1'b0, CAUSES[idx*4 +: 4]});
      r = $random(seed);
      reqSelectA <= r[0];
      reqSelectB <= r[1];
      transitionActive <= (idx == 7);
      flt <= 12'h001 << idx;
      repeat ((idx < 4 || idx == 7) ? 1 : 4) @(posedge clk);
      flt <= 12'h000;
      transitionActive <= 1'b0;
      waitLevel(10, 1'b0);
      check(dischargeBleed, 1'b1);
      waitLevel(4000, 1'b1);
      check({supplySelectA, supplySelectB, dischargeBleed}, 3'h0);
    end
  endtask
  ////////////////////////////////////////
  always @(posedge clk) begin
    if (rst_n === 1'b1 && hardResetTx === 1'b1) begin
      if (noteHr.size() == 0) check(1'b1, 1'b0);
      else if (!noteHr[0][4]) check(faultCause, noteHr.pop_front());
      else noteHr.pop_front();
    end
    if (rst_n === 1'b1 && capsSend === 1'b1) begin
      if (noteCaps.size() == 0) check(1'b1, 1'b0);
      else check({advMid, advHigh, advHalfPower}, noteCaps.pop_front());
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    mismatches = mismatches + 1;
    conclude;
  end

  initial begin
    doReset(1'b0, 1'b1, 1'b0);
    for (i = 0; i < 4; i = i + 1) capsRound;
    $display("caps 12/20 done");
    noFault(9);
    noFault(7);
    sourceRequest <= 1'b0;
    repeat (3) @(posedge clk);
    check(fetGateDrive, 1'b0);
    sourceRequest <= 1'b1;
    repeat (3) @(posedge clk);
    check(fetGateDrive, 1'b1);
    firstMsgSent <= 1'b1;
    for (i = 0; i < 12; i = i + 1) runFault(i);
    $display("fault table done");
    noteHr.push_back(5'h07);
    transitionActive <= 1'b1;
    waitLevel(60, 1'b0);
    transitionActive <= 1'b0;
    waitLevel(4000, 1'b1);
    $display("transition timeout done");
    noteHr.push_back(5'h08);
    noteHr.push_back(5'h0a);
    stall <= 2'b01;
    flt <= 12'h004;
    @(posedge clk);
    flt <= 12'h000;
    n = 0;
    while (retryCount !== 8'h01 && n < 300) begin
      @(posedge clk);
      n = n + 1;
    end
    stall <= 2'b00;
    waitLevel(4000, 1'b1);
    check(retryCount, 8'h01);
    $display("discharge retry done");
    // Supply held up after the connector is safe must repeat the procedure
    noteHr.push_back(5'h0b);
    noteHr.push_back(5'h0e);
    stall <= 2'b10;
    flt <= 12'h100;
    repeat (4) @(posedge clk);
    flt <= 12'h000;
    n = 0;
    while (faultCause !== 4'he && n < 300) begin
      @(posedge clk);
      n = n + 1;
    end
    stall <= 2'b00;
    waitLevel(4000, 1'b1);
    check(retryCount, 8'h02);
    $display("supply overvoltage done");
    doReset(1'b1, 1'b0, 1'b1);
    for (i = 0; i < 4; i = i + 1) capsRound;
    $display("caps 9/15 done");
    conclude;
  end
endmodule
